/* rtl/rccd_consts.vh */
// constants for the radio configuration command decoder
// included by rtl/rccd_top.v; definitions only
`ifndef RCCD_CONSTS_VH
`define RCCD_CONSTS_VH
`define RCCD_CFG_RST 16'h8008
`define RCCD_PWR_RST 16'h8208
`define RCCD_FRQ_RST 16'hA680
`define RCCD_RATE_RST 16'hC623
`define RCCD_RXC_RST 16'h9080
`define RCCD_FLT_RST 16'hC22C
`define RCCD_CODE_CFG 8'h80
`define RCCD_CODE_PWR 8'h82
`define RCCD_CODE_FRQ 4'hA
`define RCCD_CODE_RATE 8'hC6
`define RCCD_CODE_RXC 5'h12
`define RCCD_CODE_FLT 8'hC2
`define RCCD_FRQ_MIN 12'h060
`define RCCD_FRQ_MAX 12'hF3F
`define RCCD_FLT_FIXED 16'h0028
`define RCCD_CFG_TXREG_BIT 7
`define RCCD_CFG_FIFO_BIT 6
`define RCCD_PWR_RX_BIT 7
`define RCCD_PWR_BB_BIT 6
`define RCCD_PWR_TX_BIT 5
`define RCCD_PWR_SYN_BIT 4
`define RCCD_PWR_XO_BIT 3
`define RCCD_PWR_LBD_BIT 2
`define RCCD_PWR_WKT_BIT 1
`define RCCD_PWR_CKOFF_BIT 0
`define RCCD_RXC_PIN_BIT 10
`define RCCD_FLT_AUTO_BIT 7
`define RCCD_FLT_FAST_BIT 6
`define RCCD_FLT_RC_BIT 4
`define RCCD_WORD_BITS 16
`endif

/* rtl/rccd_top.v */
// radio configuration command decoder: serial command port and six config words
// assumes serial clock, select and data come asynchronously from a host pin
// and that the serial clock is far slower than CORE_CLK_I (160 ns vs 20 ns)
//
// Behaviour
// - bits shift in msb first on serial clock rise while select low; select high resets.
// - reset loads every command register with its default value.
// - upper byte 80h stores tx register, fifo, band and crystal load; default 8008h.
// - with fifo off, received bits drive the direct data pin; recovered clock drives the clock pin with digital filter only.
// - crystal load code is linear, 8.5 to 16.0 pF in half-pF steps.
// - upper byte 82h stores eight section enables; default 8208h.
// - transmit enable powers synth and amplifier, starts sending if tx register on.
// - clock output off bit disables the controller clock output.
// - baseband, synth and oscillator can each be held on separately.
// - top nibble Ah stores a 12-bit frequency word; default A680h.
// - frequency word below 96 or above 3903 is discarded, old kept.
// - center frequency is 10*C1*(C2+F/4000) MHz, band picks C1 and C2.
// - upper byte C6h stores prescale bit and 7-bit divisor; default C623h.
// - bit rate 10000/29/(R+1)/(1+7*cs) kbps, used for transmit and receive.
// - top bits 10010 store receiver control; bit 10 picks shared pin role.
// - valid response code: fast, medium, slow, or forced always on.
// - bandwidth code selects 400 down to 67 kHz; 000 and 111 reserved.
// - lna gain code gives 0, -6, -14, -20 dB.
// - rssi threshold -103 to -73 dBm in 6 dB steps, plus lna gain.
// - upper byte C2h stores data filter, bits 5 and 3 fixed at one.
// - fast mode bit picks fast or slow clock recovery.
// - filter bit picks digital filter or external rc filter.
// - with rc filter, clock recovery and fifo deliver no data.
`timescale 1ns/1ps
`include "rccd_consts.vh"
module rccd_top #(
	parameter WORD_BITS = `RCCD_WORD_BITS
) (
	input wire CORE_CLK_I, // 50 MHz core clock
	input wire SRST_I, // synchronous reset, active high
	input wire SCK_I, // serial clock from host
	input wire CHIP_SELECT_N_I, // serial select, active low
	input wire SERIAL_IN_I, // serial data from host
	input wire RX_BIT_I, // demodulated receive bit
	input wire RX_CLK_I, // recovered bit clock
	output wire RX_BIT_OUT_O, // direct receive data pin
	output wire RX_BIT_CLK_OUT_O, // direct receive clock pin
	output wire FIFO_DATA_VALID_O, // receive bit offered to fifo
	output wire TX_DATA_REG_ON_O, // tx data register enabled
	output wire RX_FIFO_ON_O, // receive fifo enabled
	output wire [1:0] BAND_SEL_O, // band select
	output wire [3:0] XTAL_LOAD_CODE_O, // crystal load code
	output wire RX_CHAIN_ON_O, // receiver chain power
	output wire BB_PATH_ON_O, // baseband power
	output wire PA_ON_O, // power amplifier power
	output wire SYNTH_POWER_O, // synthesizer power
	output wire XTAL_POWER_O, // crystal oscillator power
	output wire TX_START_O, // transmission of data register active
	output wire LOW_BATT_DETECT_ON_O, // battery detector power
	output wire WAKEUP_TIMER_ON_O, // wake-up timer power
	output wire CLK_OUT_EN_O, // controller clock buffer enable
	output wire [11:0] FREQ_WORD_O, // synthesizer frequency word
	output wire [1:0] C1_O, // band multiplier
	output wire [5:0] C2_O, // band offset
	output wire RATE_PRESCALE_O, // bit rate prescaler
	output wire [6:0] RATE_DIVISOR_O, // bit rate divisor
	output wire PIN_ROLE_SEL_O, // shared pin: 1 valid flag out
	output wire [1:0] VALID_RESP_CODE_O, // valid flag response
	output wire [2:0] BB_BW_CODE_O, // baseband bandwidth
	output wire [1:0] LNA_GAIN_CODE_O, // lna gain
	output wire [2:0] RSSI_THRESH_CODE_O, // rssi threshold
	output wire CR_AUTO_LOCK_O, // clock recovery auto lock
	output wire CR_FAST_MODE_O, // clock recovery fast mode
	output wire RC_FILTER_SEL_O, // 1 external rc filter
	output wire CR_ENABLE_O, // internal clock recovery usable
	output wire [2:0] QUALITY_THRESH_CODE_O // quality detector threshold
);
	reg [2:0] sck_sync_reg;
	reg [1:0] cs_sync_reg;
	reg [1:0] sdi_sync_reg;
	reg cs_last_reg;
	reg [15:0] shift_reg;
	reg [4:0] count_reg;
	reg [1:0] rx_sync_reg;
	reg [1:0] rxc_sync_reg;
	reg [15:0] cfg_reg;
	reg [15:0] pwr_reg;
	reg [15:0] frq_reg;
	reg [15:0] rate_reg;
	reg [15:0] rxc_reg;
	reg [15:0] flt_reg;
	reg [1:0] c1_reg;
	reg [5:0] c2_reg;
	wire sck_rise;
	wire cs_rise;
	wire word_done;
	wire [15:0] shift_next;
	wire frq_in_range;
	wire fifo_on;
	wire rc_sel;

	// the first stage of each synchroniser is read only by the second
	always @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			sck_sync_reg <= 3'h0;
			cs_sync_reg <= 2'h3;
			sdi_sync_reg <= 2'h0;
			rx_sync_reg <= 2'h0;
			rxc_sync_reg <= 2'h0;
			cs_last_reg <= 1'b1;
		end else begin
			sck_sync_reg <= {sck_sync_reg[1:0], SCK_I};
			cs_sync_reg <= {cs_sync_reg[0], CHIP_SELECT_N_I};
			sdi_sync_reg <= {sdi_sync_reg[0], SERIAL_IN_I};
			rx_sync_reg <= {rx_sync_reg[0], RX_BIT_I};
			rxc_sync_reg <= {rxc_sync_reg[0], RX_CLK_I};
			cs_last_reg <= cs_sync_reg[1];
		end
	end

	// data is sampled with the clock edge, both delayed equally by two stages
	assign sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
	assign cs_rise = cs_sync_reg[1] & ~cs_last_reg;
	assign shift_next = {shift_reg[14:0], sdi_sync_reg[1]};
	// longer words than sixteen never raise word_done and are dropped undecoded
	assign word_done = cs_rise & (count_reg == WORD_BITS);

	always @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			shift_reg <= 16'h0000;
			count_reg <= 5'h00;
		end else if (cs_sync_reg[1]) begin
			count_reg <= 5'h00;
		end else if (sck_rise) begin
			shift_reg <= shift_next;
			if (count_reg != 5'h1F) begin
				count_reg <= count_reg + 5'h01;
			end
		end
	end

	assign frq_in_range = (shift_reg[11:0] >= `RCCD_FRQ_MIN) &&
		(shift_reg[11:0] <= `RCCD_FRQ_MAX);

	// commands are applied when select rises; anything else keeps state
	always @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			cfg_reg <= `RCCD_CFG_RST;
			pwr_reg <= `RCCD_PWR_RST;
			frq_reg <= `RCCD_FRQ_RST;
			rate_reg <= `RCCD_RATE_RST;
			rxc_reg <= `RCCD_RXC_RST;
			flt_reg <= `RCCD_FLT_RST;
		end else if (word_done) begin
			if (shift_reg[15:8] == `RCCD_CODE_CFG) begin
				cfg_reg <= shift_reg;
			end
			if (shift_reg[15:8] == `RCCD_CODE_PWR) begin
				pwr_reg <= shift_reg;
			end
			if (shift_reg[15:12] == `RCCD_CODE_FRQ && frq_in_range) begin
				frq_reg <= shift_reg;
			end
			if (shift_reg[15:8] == `RCCD_CODE_RATE) begin
				rate_reg <= shift_reg;
			end
			if (shift_reg[15:11] == `RCCD_CODE_RXC) begin
				rxc_reg <= shift_reg;
			end
			if (shift_reg[15:8] == `RCCD_CODE_FLT) begin
				flt_reg <= shift_reg | `RCCD_FLT_FIXED;
			end
			// no match: all registers hold
		end
	end

	// band constants for the frequency formula, downstream does the arithmetic
	always @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			c1_reg <= 2'h1;
			c2_reg <= 6'h1F;
		end else begin
			case (cfg_reg[5:4])
				2'h0: begin
					c1_reg <= 2'h1;
					c2_reg <= 6'h1F;
				end
				2'h1: begin
					c1_reg <= 2'h1;
					c2_reg <= 6'h2B;
				end
				2'h2: begin
					c1_reg <= 2'h2;
					c2_reg <= 6'h2B;
				end
				default: begin
					c1_reg <= 2'h3;
					c2_reg <= 6'h1E;
				end
			endcase
		end
	end

	assign fifo_on = cfg_reg[`RCCD_CFG_FIFO_BIT];
	assign rc_sel = flt_reg[`RCCD_FLT_RC_BIT];

	// direct data pin carries data whenever fifo is off; the direct clock pin also needs the digital filter path
	assign RX_BIT_OUT_O = ~fifo_on & rx_sync_reg[1];
	assign RX_BIT_CLK_OUT_O = ~fifo_on & ~rc_sel & rxc_sync_reg[1];
	assign FIFO_DATA_VALID_O = fifo_on & ~rc_sel & rxc_sync_reg[1];
	assign CR_ENABLE_O = ~rc_sel;
	assign RC_FILTER_SEL_O = rc_sel;

	assign TX_DATA_REG_ON_O = cfg_reg[`RCCD_CFG_TXREG_BIT];
	assign RX_FIFO_ON_O = fifo_on;
	assign BAND_SEL_O = cfg_reg[5:4];
	assign XTAL_LOAD_CODE_O = cfg_reg[3:0];

	assign RX_CHAIN_ON_O = pwr_reg[`RCCD_PWR_RX_BIT];
	// receiver chain also needs baseband, synth and oscillator
	assign BB_PATH_ON_O = pwr_reg[`RCCD_PWR_BB_BIT] | pwr_reg[`RCCD_PWR_RX_BIT];
	assign PA_ON_O = pwr_reg[`RCCD_PWR_TX_BIT];
	assign SYNTH_POWER_O = pwr_reg[`RCCD_PWR_SYN_BIT] | pwr_reg[`RCCD_PWR_TX_BIT] |
		pwr_reg[`RCCD_PWR_RX_BIT];
	assign XTAL_POWER_O = pwr_reg[`RCCD_PWR_XO_BIT] | pwr_reg[`RCCD_PWR_TX_BIT] |
		pwr_reg[`RCCD_PWR_RX_BIT];
	assign TX_START_O = pwr_reg[`RCCD_PWR_TX_BIT] & cfg_reg[`RCCD_CFG_TXREG_BIT];
	assign LOW_BATT_DETECT_ON_O = pwr_reg[`RCCD_PWR_LBD_BIT];
	assign WAKEUP_TIMER_ON_O = pwr_reg[`RCCD_PWR_WKT_BIT];
	assign CLK_OUT_EN_O = ~pwr_reg[`RCCD_PWR_CKOFF_BIT];

	assign FREQ_WORD_O = frq_reg[11:0];
	assign C1_O = c1_reg;
	assign C2_O = c2_reg;
	// one rate setting serves both directions
	assign RATE_PRESCALE_O = rate_reg[7];
	assign RATE_DIVISOR_O = rate_reg[6:0];

	assign PIN_ROLE_SEL_O = rxc_reg[`RCCD_RXC_PIN_BIT];
	assign VALID_RESP_CODE_O = rxc_reg[9:8];
	// reserved bandwidth and threshold codes are passed unchanged
	assign BB_BW_CODE_O = rxc_reg[7:5];
	assign LNA_GAIN_CODE_O = rxc_reg[4:3];
	assign RSSI_THRESH_CODE_O = rxc_reg[2:0];

	assign CR_AUTO_LOCK_O = flt_reg[`RCCD_FLT_AUTO_BIT];
	assign CR_FAST_MODE_O = flt_reg[`RCCD_FLT_FAST_BIT];
	assign QUALITY_THRESH_CODE_O = flt_reg[2:0];
endmodule

/* sim/rccd_host.sv */
// host model: shifts command words into the serial command port
// assumes the 50 MHz core clock; serial clock period 160 ns, idle low
`timescale 1ns/1ps
module rccd_host (
	input wire clk_i, // core clock
	output reg sck_o, // serial clock
	output reg cs_n_o, // select, active low
	output reg sdi_o // serial data
);
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o = 1'b0;
	end
	task automatic tick(input integer n);
		repeat (n) @(posedge clk_i);
	endtask
	// n low bits of w, msb first, data set half a period before each rise
	task automatic send(input [31:0] w, input integer n);
		integer i;
		begin
		cs_n_o <= 1'b0;
		for (i = n - 1; i >= 0; i = i - 1) begin
			sdi_o <= w[i];
			tick(4);
			sck_o <= 1'b1;
			tick(4);
			sck_o <= 1'b0;
		end
		tick(2);
		cs_n_o <= 1'b1;
		sdi_o <= ~sdi_o; // released line must not show the last bit
		tick(8);
		end
	endtask
endmodule

/* sim/rccd_props.sv */
// assertions on the decoder's top-level ports
// bound into every rccd_top instance
`timescale 1ns/1ps
module rccd_props (
	input wire CORE_CLK_I, SRST_I, CHIP_SELECT_N_I, // clock, reset, select
	input wire RX_BIT_OUT_O, RX_BIT_CLK_OUT_O, FIFO_DATA_VALID_O, // receive path
	input wire TX_DATA_REG_ON_O, RX_FIFO_ON_O, RX_CHAIN_ON_O, BB_PATH_ON_O, // enables
	input wire PA_ON_O, SYNTH_POWER_O, XTAL_POWER_O, TX_START_O, CLK_OUT_EN_O, // power
	input wire RC_FILTER_SEL_O, CR_ENABLE_O, // filter
	input wire [1:0] BAND_SEL_O, C1_O, // band
	input wire [5:0] C2_O, // band offset
	input wire [11:0] FREQ_WORD_O, // frequency word
	input wire [6:0] RATE_DIVISOR_O // divisor
);
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (SRST_I);
	function automatic [7:0] band_c(input [1:0] b);
		band_c = (b == 2'b00) ? 8'h5F : (b == 2'b01) ? 8'h6B : (b == 2'b10) ? 8'hAB : 8'hDE;
	endfunction
	a_tx_start_gate: assert property (TX_START_O == (PA_ON_O && TX_DATA_REG_ON_O))
		else $error("tx start gating wrong");
	a_tx_powers: assert property (PA_ON_O |-> SYNTH_POWER_O && XTAL_POWER_O)
		else $error("transmit without synth or oscillator");
	a_rx_chain_power: assert property (RX_CHAIN_ON_O |->
		BB_PATH_ON_O && SYNTH_POWER_O && XTAL_POWER_O) else $error("receiver chain without its sections");
	a_freq_in_range: assert property (FREQ_WORD_O >= 12'h060 && FREQ_WORD_O <= 12'hF3F)
		else $error("frequency word out of range");
	a_rc_blocks_cr: assert property (RC_FILTER_SEL_O |-> !FIFO_DATA_VALID_O && !RX_BIT_CLK_OUT_O)
		else $error("rc filter still delivers clock");
	a_cr_enable_inv: assert property (CR_ENABLE_O != RC_FILTER_SEL_O)
		else $error("recovery enable not tied to filter");
	a_fifo_mutes_pin: assert property (RX_FIFO_ON_O |-> !RX_BIT_OUT_O && !RX_BIT_CLK_OUT_O)
		else $error("direct pins active with fifo on");
	a_select_low_hold: assert property (!CHIP_SELECT_N_I [*6] |=>
		$stable({FREQ_WORD_O, RATE_DIVISOR_O, BAND_SEL_O, CLK_OUT_EN_O})) else $error("update in frame");
	a_band_consts: assert property ($stable(BAND_SEL_O) |-> {C1_O, C2_O} == band_c(BAND_SEL_O))
		else $error("band constants wrong");
	cover property ($rose(TX_START_O));
	cover property ($rose(RC_FILTER_SEL_O));
	cover property (RX_BIT_OUT_O && RX_BIT_CLK_OUT_O);
endmodule
bind rccd_top rccd_props i_props (.*);

/* sim/tb_top.sv */
// self-checking bench for the command decoder
// host model drives the serial port; receive inputs are driven here
`timescale 1ns/1ps
module tb_top;
	reg CORE_CLK_I = 1'b0;
	reg SRST_I = 1'b1;
	reg RX_BIT_I = 1'b0;
	reg RX_CLK_I = 1'b0;
	wire SCK_I, CHIP_SELECT_N_I, SERIAL_IN_I, PIN_ROLE_SEL_O, CR_AUTO_LOCK_O, CR_FAST_MODE_O;
	wire RX_BIT_OUT_O, RX_BIT_CLK_OUT_O, FIFO_DATA_VALID_O, TX_DATA_REG_ON_O, RX_FIFO_ON_O;
	wire RX_CHAIN_ON_O, BB_PATH_ON_O, PA_ON_O, SYNTH_POWER_O, XTAL_POWER_O, TX_START_O;
	wire LOW_BATT_DETECT_ON_O, WAKEUP_TIMER_ON_O, CLK_OUT_EN_O, RATE_PRESCALE_O;
	wire RC_FILTER_SEL_O, CR_ENABLE_O;
	wire [1:0] BAND_SEL_O, C1_O, VALID_RESP_CODE_O, LNA_GAIN_CODE_O;
	wire [3:0] XTAL_LOAD_CODE_O;
	wire [11:0] FREQ_WORD_O;
	wire [5:0] C2_O;
	wire [6:0] RATE_DIVISOR_O;
	wire [2:0] BB_BW_CODE_O, RSSI_THRESH_CODE_O, QUALITY_THRESH_CODE_O;
	reg [7:0] e_cfg = 8'h08, e_pwr = 8'h09, e_rate = 8'h23, e_band = 8'h5F;
	reg [11:0] e_frq = 12'h680;
	reg [10:0] e_rxc = 11'h080;
	reg [6:0] e_flt = 7'h0C;
	reg e_tx = 1'b0;
	integer num_errors = 0;
	integer checked = 0;
	integer b;
	wire [62:0] e_all = {e_cfg, e_pwr, e_frq, e_rate, e_rxc, e_flt, e_band, e_tx};
	wire [62:0] st = {TX_DATA_REG_ON_O, RX_FIFO_ON_O, BAND_SEL_O, XTAL_LOAD_CODE_O,
		RX_CHAIN_ON_O, BB_PATH_ON_O, PA_ON_O, SYNTH_POWER_O, XTAL_POWER_O,
		LOW_BATT_DETECT_ON_O, WAKEUP_TIMER_ON_O, CLK_OUT_EN_O, FREQ_WORD_O, RATE_PRESCALE_O,
		RATE_DIVISOR_O, PIN_ROLE_SEL_O, VALID_RESP_CODE_O, BB_BW_CODE_O, LNA_GAIN_CODE_O,
		RSSI_THRESH_CODE_O, CR_AUTO_LOCK_O, CR_FAST_MODE_O, RC_FILTER_SEL_O, CR_ENABLE_O,
		QUALITY_THRESH_CODE_O, C1_O, C2_O, TX_START_O};
	wire [62:0] rx_path = 63'({RX_BIT_OUT_O, RX_BIT_CLK_OUT_O, FIFO_DATA_VALID_O});
	rccd_top i_dut (.*);
	rccd_host i_host (
		.clk_i(CORE_CLK_I),
		.sck_o(SCK_I),
		.cs_n_o(CHIP_SELECT_N_I),
		.sdi_o(SERIAL_IN_I)
	);
	initial forever #10 CORE_CLK_I = ~CORE_CLK_I;
	task automatic chk(input [95:0] nm, input [62:0] e, input [62:0] g);
		begin
		checked = checked + 1;
		if (g !== e) begin
			num_errors = num_errors + 1;
			$display("[FAIL] %0s expected %h seen %h", nm, e, g);
		end
		end
	endtask
	// whole config view is compared, so untouched registers are checked too
	task automatic cmd(input [15:0] w);
		begin
		i_host.send({16'h0000, w}, 16);
		chk("config", e_all, st);
		end
	endtask
	task automatic report_and_stop;
		begin
		if (num_errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
		end
	endtask
	initial begin
		#1000000;
		num_errors = num_errors + 1;
		report_and_stop;
	end
	initial begin
		repeat (4) @(posedge CORE_CLK_I);
		SRST_I <= 1'b0;
		repeat (3) @(posedge CORE_CLK_I);
		chk("config", e_all, st);
		for (b = 0; b < 4; b = b + 1) begin
			e_cfg = {2'b11, b[1:0], 4'h5};
			e_band = 8'(32'h5F6BABDE >> (8 * (3 - b)));
			cmd({8'h80, 2'b11, b[1:0], 4'h5});
		end
		e_pwr = 8'h38;
		e_tx = 1'b1;
		cmd(16'h8221);
		e_pwr = 8'hDF;
		e_tx = 1'b0;
		cmd(16'h82C6);
		e_pwr = 8'h51;
		cmd(16'h8250);
		cmd(16'hA05F);
		cmd(16'hAF40);
		e_frq = 12'h060;
		cmd(16'hA060);
		e_frq = 12'hF3F;
		cmd(16'hAF3F);
		e_rate = 8'hFF;
		cmd(16'hC6FF);
		e_rxc = 11'h7FF;
		cmd(16'h97FF);
		e_rxc = 11'h355;
		cmd(16'h9355);
		cmd(16'hCA80);
		cmd(16'hB8AA);
		i_host.send(32'h0000A100, 15);
		chk("short word", e_all, st);
		i_host.send(32'h00014200, 17);
		chk("long word", e_all, st);
		e_flt = 7'h77;
		cmd(16'hC2D7);
		RX_BIT_I <= 1'b1;
		RX_CLK_I <= 1'b1;
		e_cfg = 8'h00;
		e_band = 8'h5F;
		cmd(16'h8000);
		chk("rx path", 63'(3'b100), rx_path);
		e_flt = 7'h08;
		cmd(16'hC228);
		chk("rx path", 63'(3'b110), rx_path);
		e_cfg = 8'h40;
		cmd(16'h8040);
		chk("rx path", 63'(3'b001), rx_path);
		report_and_stop;
	end
endmodule
